// [common/tprm_pkg.sv]
// Package for the timer and interrupt pin remapping unit
package tprm_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0] TPRM_ADDR_IN_SEL = 4'h0;
    localparam logic [3:0] TPRM_ADDR_OUT_SEL = 4'h1;
    localparam logic [3:0] TPRM_ADDR_PORTA_DATA = 4'h2;
    localparam logic [3:0] TPRM_ADDR_PORTA_DIR = 4'h3;
    localparam logic [3:0] TPRM_ADDR_WAKE_EN = 4'h4;
    localparam logic [3:0] TPRM_ADDR_PORTA_PIN = 4'h5;
    localparam logic [3:0] TPRM_ADDR_STATUS = 4'h6;
    // ==========================================================
    // Reset values
    localparam logic [7:0] TPRM_SEL_RESET = 8'h00;
    localparam logic [7:0] TPRM_PORT_RESET = 8'hff;
    localparam logic [7:0] TPRM_WAKE_RESET = 8'h00;
    // ==========================================================
    // Bit positions, input select
    localparam int TPRM_B_TIMER2_CLOCK_INPUT = 7;
    localparam int TPRM_B_TIMER1_CLOCK_INPUT = 6;
    localparam int TPRM_B_TIMER0_CLOCK_INPUT = 5;
    localparam int TPRM_B_IRQ2 = 4;
    localparam int TPRM_B_IRQ1 = 3;
    localparam int TPRM_B_IRQ0 = 2;
    localparam int TPRM_B_T1B1 = 1;
    localparam int TPRM_B_T1B0 = 0;
    // Bit positions, output select
    localparam int TPRM_B_T3B = 7;
    localparam int TPRM_B_T3A = 6;
    localparam int TPRM_B_T2B = 5;
    localparam int TPRM_B_T2A = 4;
    localparam int TPRM_B_T1B2 = 3;
    localparam int TPRM_B_T1A = 2;
    localparam int TPRM_B_T0B = 1;
    localparam int TPRM_B_T0A = 0;
    // Writable masks per variant (timer count 2, 3, 4)
    localparam logic [7:0] TPRM_OUT_MASK_2 = 8'h07;
    localparam logic [7:0] TPRM_OUT_MASK_3 = 8'h3f;
    localparam logic [7:0] TPRM_OUT_MASK_4 = 8'hff;
    localparam logic [7:0] TPRM_IN_MASK_2 = 8'h6f;
    localparam logic [7:0] TPRM_IN_MASK_3 = 8'hef;
    localparam logic [7:0] TPRM_IN_MASK_4 = 8'hff;
    // ==========================================================
    // Types
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tprm_bus_t;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] c;
        logic [7:0] d;
        logic [7:0] e;
        logic [7:0] f;
        logic [7:0] g;
    } tprm_ports_t;

    typedef struct packed {
        logic timer2_clock_input;
        logic timer1_clock_input;
        logic timer0_clock_input;
        logic irq2;
        logic irq1_n;
        logic irq0_n;
    } tprm_ins_t;

    typedef struct packed {
        logic t0a;
        logic t0b;
        logic t1a;
        logic t1b0;
        logic t1b1;
        logic t1b2;
        logic t2a;
        logic t2b;
        logic t3a;
        logic t3b;
    } tprm_outs_t;

    typedef enum logic [2:0] {
        TPRM_AWAKE = 3'b001,
        TPRM_ASLEEP = 3'b010,
        TPRM_WAKING = 3'b100
    } tprm_pwr_t;
endpackage : tprm_pkg

// [sim/test_tprm_top.sv]
// Self-checking testbench for the timer pin remap unit
`timescale 1ns/100ps
module test_tprm_top;
    import tprm_pkg::*;
    // ==========================================================
    // Signals
    logic mclk;
    logic reset;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic bit_op;
    logic bit_set;
    logic [2:0] bit_idx;
    logic [7:0] reg_rdata;
    logic [7:0] reg_rdata2;
    tprm_ports_t pin_in;
    tprm_ports_t other_fn;
    tprm_ports_t pin_out;
    tprm_ports_t pin_timer_sel;
    tprm_ports_t ow;
    tprm_ports_t sel2;
    logic [7:0] porta_oe;
    tprm_outs_t timer_outs;
    tprm_ins_t timer_ins;
    logic sleep_req;
    logic asleep;
    logic wake_pulse;
    logic [7:0] p;
    logic [7:0] pat [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
    int fails;
    int n_tests;
    int n_wake;
    // Second unit shows the masked two-timer layout
    tprm_top #(.NUM_TIMERS(4)) uut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .bit_op, .bit_set, .bit_idx, .reg_rdata, .pin_in, .other_fn, .pin_out, .pin_timer_sel,
        .porta_oe, .timer_outs, .timer_ins, .sleep_req, .asleep, .wake_pulse);
    tprm_top #(.NUM_TIMERS(2)) uut2 (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .bit_op, .bit_set, .bit_idx, .reg_rdata(reg_rdata2), .pin_in, .other_fn, .pin_out(),
        .pin_timer_sel(sel2), .porta_oe(), .timer_outs, .timer_ins(), .sleep_req, .asleep(),
        .wake_pulse());
    // ==========================================================
    // Clock, watchdog, wake counter
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        final_report();
    end
    always @(posedge mclk) begin
        if (wake_pulse === 1'b1) n_wake++;
    end
    // ==========================================================
    // Tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic b, input logic s);
        reg_addr <= a;
        reg_wdata <= d;
        bit_op <= b;
        bit_set <= s;
        bit_idx <= d[2:0];
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        bit_op <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] e2);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        check({reg_rdata, reg_rdata2}, {e, e2});
        @(posedge mclk);
    endtask : rdc
    task automatic settle();
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask : settle
    // Pins owned by timer outputs, four-timer layout
    function automatic tprm_ports_t own_map(input logic [7:0] i, input logic [7:0] s);
        tprm_ports_t m;
        m = '0;
        m.c[1:0] = ~i[1:0];
        m.d[4:3] = i[1:0];
        m.a[1] = ~s[2];
        m.a[0] = ~s[0];
        m.d[2:0] = s[2:0];
        m.c[5] = ~s[1] | ~s[3];
        m.d[5] = s[3];
        m.c[4:3] = ~s[5:4];
        m.d[7:6] = s[5:4];
        m.f[1:0] = s[7:6];
        m.g[0] = ~s[7];
        m.g[3] = ~s[6];
        return m;
    endfunction : own_map
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    // ==========================================================
    // Tests
    initial begin
        reset = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, bit_op, bit_set, bit_idx, sleep_req} = '0;
        pin_in = '0;
        other_fn = '0;
        timer_outs = '0;
        {fails, n_tests, n_wake} = '0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rdc(TPRM_ADDR_IN_SEL, 8'h00, 8'h00);
        rdc(TPRM_ADDR_OUT_SEL, 8'h00, 8'h00);
        rdc(TPRM_ADDR_PORTA_DATA, 8'hff, 8'hff);
        rdc(TPRM_ADDR_PORTA_DIR, 8'hff, 8'hff);
        rdc(TPRM_ADDR_WAKE_EN, 8'h00, 8'h00);
        rdc(4'h7, 8'h00, 8'h00);
        check(porta_oe, 8'h00);
        $display("test reset done");
        foreach (pat[k]) begin
            p = pat[k];
            ow = own_map(p, p);
            pin_in <= {8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
            other_fn <= '0;
            timer_outs <= '1;
            wr(TPRM_ADDR_IN_SEL, p, 1'b0, 1'b0);
            @(posedge mclk);
            wr(TPRM_ADDR_OUT_SEL, p, 1'b0, 1'b0);
            // Read straight after the write, no gap
            rdc(TPRM_ADDR_OUT_SEL, p, p & 8'h07);
            settle();
            check(timer_ins, p[7:2]);
            check(pin_timer_sel, ow);
            check(sel2.a[7], {~p[1]});
            check({pin_out.c, pin_out.d, pin_out.f, pin_out.g}, {ow.c, ow.d, ow.f, ow.g});
            @(posedge mclk);
            pin_in <= {8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
            other_fn <= '1;
            timer_outs <= '0;
            settle();
            check(timer_ins, {~p[7:2]});
            check({pin_out.c, pin_out.d, pin_out.f, pin_out.g}, {~{ow.c, ow.d, ow.f, ow.g}});
            @(posedge mclk);
            rdc(TPRM_ADDR_IN_SEL, p, p & 8'h6f);
        end
        wr(TPRM_ADDR_OUT_SEL, 8'h00, 1'b0, 1'b0);
        other_fn <= '0;
        timer_outs <= 10'h010;
        settle();
        check(pin_out.c[5], 1'b1);
        $display("test routing done");
        @(posedge mclk);
        wr(TPRM_ADDR_PORTA_DIR, 8'h00, 1'b0, 1'b0);
        settle();
        check(porta_oe, 8'hff);
        check(pin_out.a[7:2], 6'h3f);
        @(posedge mclk);
        wr(TPRM_ADDR_PORTA_DATA, 8'h00, 1'b0, 1'b0);
        pin_in <= {8'h5a, 40'h0};
        settle();
        check(pin_out.a[7:2], 6'h00);
        @(posedge mclk);
        wr(TPRM_ADDR_PORTA_DATA, 8'h01, 1'b1, 1'b0);
        rdc(TPRM_ADDR_PORTA_DATA, 8'h58, 8'h58);
        rdc(TPRM_ADDR_PORTA_PIN, 8'h5a, 8'h5a);
        wr(TPRM_ADDR_PORTA_DIR, 8'h07, 1'b1, 1'b1);
        rdc(TPRM_ADDR_PORTA_DIR, 8'h80, 8'h80);
        check(porta_oe, 8'h7f);
        $display("test port done");
        wr(TPRM_ADDR_WAKE_EN, 8'h10, 1'b0, 1'b0);
        pin_in <= {8'hff, 40'h0};
        sleep_req <= 1'b1;
        @(posedge mclk);
        sleep_req <= 1'b0;
        rdc(TPRM_ADDR_STATUS, 8'h01, 8'h01);
        pin_in <= {8'hf7, 40'h0};
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        check({asleep, n_wake[7:0]}, {1'b1, 8'h00});
        @(posedge mclk);
        pin_in <= {8'he7, 40'h0};
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        check({asleep, n_wake[7:0]}, {1'b0, 8'h01});
        $display("test wake done");
        final_report();
    end
endmodule : test_tprm_top

// [sim/tprm_checker.sv]
// Assertion checker for the timer pin remap unit
`timescale 1ns/100ps
module tprm_checker
    import tprm_pkg::*;
#(
    parameter int NUM_TIMERS = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic bit_op,
    input wire logic [7:0] reg_rdata,
    input wire tprm_ports_t pin_in,
    input wire tprm_ports_t other_fn,
    input wire tprm_ports_t pin_out,
    input wire tprm_ports_t pin_timer_sel,
    input wire logic [7:0] porta_oe,
    input wire tprm_outs_t timer_outs,
    input wire tprm_ins_t timer_ins,
    input wire logic sleep_req,
    input wire logic asleep,
    input wire logic wake_pulse
);
    // ==========================================================
    // Shadow selects
    logic [7:0] in_mask;
    logic [7:0] out_mask;
    logic [7:0] in_q;
    logic [7:0] out_q;
    tprm_ins_t exp_q;
    assign in_mask = (NUM_TIMERS == 2) ? TPRM_IN_MASK_2 :
        ((NUM_TIMERS == 3) ? TPRM_IN_MASK_3 : TPRM_IN_MASK_4);
    assign out_mask = (NUM_TIMERS == 2) ? TPRM_OUT_MASK_2 :
        ((NUM_TIMERS == 3) ? TPRM_OUT_MASK_3 : TPRM_OUT_MASK_4);
    // Byte writes only; bit ops on selects not tracked
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            in_q <= TPRM_SEL_RESET;
            out_q <= TPRM_SEL_RESET;
        end else if (reg_wr && !bit_op && reg_addr == TPRM_ADDR_IN_SEL) begin
            in_q <= reg_wdata & in_mask;
        end else if (reg_wr && !bit_op && reg_addr == TPRM_ADDR_OUT_SEL) begin
            out_q <= reg_wdata & out_mask;
        end
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            exp_q <= '0;
        end else begin
            exp_q.timer2_clock_input <= in_q[7] ? pin_in.e[2] : pin_in.c[2];
            exp_q.timer1_clock_input <= in_q[6] ? pin_in.e[1] : pin_in.a[4];
            exp_q.timer0_clock_input <= in_q[5] ? pin_in.e[0] : pin_in.a[2];
            exp_q.irq2 <= in_q[4] ? pin_in.e[6] : pin_in.c[4];
            exp_q.irq1_n <= in_q[3] ? pin_in.e[5] : pin_in.a[4];
            exp_q.irq0_n <= in_q[2] ? pin_in.e[4] : pin_in.a[3];
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sel_readback_a: assert property (reg_wr && !bit_op && reg_addr == TPRM_ADDR_OUT_SEL ##1
        reg_rd && reg_addr == TPRM_ADDR_OUT_SEL |=> reg_rdata == ($past(reg_wdata, 2) & out_mask))
        else $error("output select readback wrong");
    oe_dir_a: assert property (reg_wr && !bit_op && reg_addr == TPRM_ADDR_PORTA_DIR
        |=> porta_oe == ~$past(reg_wdata)) else $error("output enable not from direction");
    tck_route_a: assert property (timer_ins.timer2_clock_input == exp_q.timer2_clock_input && timer_ins.timer1_clock_input == exp_q.timer1_clock_input
        && timer_ins.timer0_clock_input == exp_q.timer0_clock_input) else $error("timer clock input misrouted");
    irq_route_a: assert property ({timer_ins.irq2, timer_ins.irq1_n, timer_ins.irq0_n} ==
        {exp_q.irq2, exp_q.irq1_n, exp_q.irq0_n}) else $error("interrupt input misrouted");
    t0a_own_a: assert property (reg_wr && !bit_op && reg_addr == TPRM_ADDR_OUT_SEL |-> ##2
        pin_timer_sel.d[0] == $past(reg_wdata[0], 2) && pin_timer_sel.a[0] != pin_timer_sel.d[0])
        else $error("timer0 a owner wrong");
    t3_own_a: assert property (reg_wr && !bit_op && reg_addr == TPRM_ADDR_OUT_SEL |-> ##2
        pin_timer_sel.f[1:0] == ($past(reg_wdata[7:6], 2) & out_mask[7:6]))
        else $error("timer3 owner wrong");
    t0a_drive_a: assert property ($past(out_q[0]) |-> pin_out.d[0] == $past(timer_outs.t0a))
        else $error("timer0 a not driven");
    d0_other_a: assert property (!$past(reset) && !$past(out_q[0]) |->
        pin_out.d[0] == $past(other_fn.d[0])) else $error("pin lost its other function");
    sleep_enter_a: assert property (sleep_req && !asleep && !wake_pulse |=> asleep)
        else $error("sleep not entered");
    wake_gap_a: assert property (wake_pulse |=> !wake_pulse && !asleep)
        else $error("wake pulse too long");
    wake_cause_a: assert property (wake_pulse |-> $past(asleep))
        else $error("wake without sleep");
    cover property (reg_wr && reg_addr == TPRM_ADDR_OUT_SEL);
    cover property (sleep_req ##1 asleep);
    cover property (wake_pulse);
endmodule : tprm_checker

bind tprm_top tprm_checker #(.NUM_TIMERS(NUM_TIMERS)) u_chk (.mclk, .reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .bit_op, .reg_rdata, .pin_in, .other_fn, .pin_out,
    .pin_timer_sel, .porta_oe, .timer_outs, .timer_ins, .sleep_req, .asleep, .wake_pulse);

// [verilog/tprm_top.sv]
// Timer and interrupt pin remapping unit with Port A control
`timescale 1ns/100ps
module tprm_top
    import tprm_pkg::*;
#(
    parameter int NUM_TIMERS = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic bit_op,
    input wire logic bit_set,
    input wire logic [2:0] bit_idx,
    output logic [7:0] reg_rdata,
    input wire tprm_ports_t pin_in,
    input wire tprm_ports_t other_fn,
    output tprm_ports_t pin_out,
    output tprm_ports_t pin_timer_sel,
    output logic [7:0] porta_oe,
    input wire tprm_outs_t timer_outs,
    output tprm_ins_t timer_ins,
    input wire logic sleep_req,
    output logic asleep,
    output logic wake_pulse
);
    tprm_bus_t bus;
    logic [7:0] in_sel_q;
    logic [7:0] out_sel_q;
    logic [7:0] pa_data_q;
    logic [7:0] pa_dir_q;
    logic [7:0] wake_en_q;
    logic [7:0] rdata_q;
    logic [7:0] in_mask;
    logic [7:0] out_mask;
    logic [7:0] rmw_src;
    logic [7:0] wval;
    tprm_ports_t route_q;
    tprm_ports_t sel_q;
    logic [7:0] pa_drive;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ==========================================================
    // Helpers
    function automatic logic [7:0] tprm_bitop(input logic [7:0] v, input logic [2:0] i,
                                              input logic s);
        logic [7:0] r;
        r = v;
        r[i] = s;
        return r;
    endfunction : tprm_bitop

    function automatic logic [7:0] tprm_read(input logic [3:0] a, input logic [7:0] ins,
                                             input logic [7:0] outs, input logic [7:0] pd,
                                             input logic [7:0] pc, input logic [7:0] we,
                                             input logic [7:0] pin, input logic sl);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            TPRM_ADDR_IN_SEL: r = ins;
            TPRM_ADDR_OUT_SEL: r = outs;
            TPRM_ADDR_PORTA_DATA: r = pd;
            TPRM_ADDR_PORTA_DIR: r = pc;
            TPRM_ADDR_WAKE_EN: r = we;
            TPRM_ADDR_PORTA_PIN: r = pin;
            TPRM_ADDR_STATUS: r = {7'h00, sl};
            default: r = 8'h00;
        endcase
        return r;
    endfunction : tprm_read

    // ==========================================================
    // Variant masks
    always_comb begin
        case (NUM_TIMERS)
            2: begin
                in_mask = TPRM_IN_MASK_2;
                out_mask = TPRM_OUT_MASK_2;
            end
            3: begin
                in_mask = TPRM_IN_MASK_3;
                out_mask = TPRM_OUT_MASK_3;
            end
            default: begin
                in_mask = TPRM_IN_MASK_4;
                out_mask = TPRM_OUT_MASK_4;
            end
        endcase
    end

    // ==========================================================
    // Write value with bit operations
    // read whole port, modify, write back
    always_comb begin
        case (bus.addr)
            TPRM_ADDR_PORTA_DATA: rmw_src = pin_in.a;
            TPRM_ADDR_PORTA_DIR: rmw_src = pa_dir_q;
            default: rmw_src = tprm_read(bus.addr, in_sel_q, out_sel_q, pa_data_q,
                                         pa_dir_q, wake_en_q, pin_in.a, asleep);
        endcase
        wval = bit_op ? tprm_bitop(rmw_src, bit_idx, bit_set) : bus.wdata;
    end

    // ==========================================================
    // Select registers
    // takes effect at next edge
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            in_sel_q <= TPRM_SEL_RESET;
        end else if (bus.wr && bus.addr == TPRM_ADDR_IN_SEL) begin
            in_sel_q <= wval & in_mask;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            out_sel_q <= TPRM_SEL_RESET;
        end else if (bus.wr && bus.addr == TPRM_ADDR_OUT_SEL) begin
            out_sel_q <= wval & out_mask;
        end
    end

    // ==========================================================
    // Port A registers
    // data and direction reset high
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pa_data_q <= TPRM_PORT_RESET;
        end else if (bus.wr && bus.addr == TPRM_ADDR_PORTA_DATA) begin
            pa_data_q <= wval;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pa_dir_q <= TPRM_PORT_RESET;
        end else if (bus.wr && bus.addr == TPRM_ADDR_PORTA_DIR) begin
            pa_dir_q <= wval;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wake_en_q <= TPRM_WAKE_RESET;
        end else if (bus.wr && bus.addr == TPRM_ADDR_WAKE_EN) begin
            wake_en_q <= wval;
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            rdata_q <= tprm_read(bus.addr, in_sel_q, out_sel_q, pa_data_q, pa_dir_q,
                                 wake_en_q, pin_in.a, asleep);
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // ==========================================================
    // Output routing
    // Timer drive replaces the other function only on the chosen pin
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            route_q <= '0;
            sel_q <= '0;
        end else begin
            route_q <= other_fn;
            sel_q <= '0;
            if (out_sel_q[TPRM_B_T0A]) begin
                route_q.d[0] <= timer_outs.t0a;
                sel_q.d[0] <= 1'b1;
            end else begin
                route_q.a[0] <= timer_outs.t0a;
                sel_q.a[0] <= 1'b1;
            end
            // timer0 out b, variant default pin
            if (out_sel_q[TPRM_B_T0B]) begin
                route_q.d[1] <= timer_outs.t0b;
                sel_q.d[1] <= 1'b1;
            end else if (NUM_TIMERS == 2) begin
                route_q.a[7] <= timer_outs.t0b;
                sel_q.a[7] <= 1'b1;
            end else begin
                route_q.c[5] <= timer_outs.t0b;
                sel_q.c[5] <= 1'b1;
            end
            if (out_sel_q[TPRM_B_T1A]) begin
                route_q.d[2] <= timer_outs.t1a;
                sel_q.d[2] <= 1'b1;
            end else begin
                route_q.a[1] <= timer_outs.t1a;
                sel_q.a[1] <= 1'b1;
            end
            if (in_sel_q[TPRM_B_T1B0]) begin
                route_q.d[3] <= timer_outs.t1b0;
                sel_q.d[3] <= 1'b1;
            end else begin
                route_q.c[0] <= timer_outs.t1b0;
                sel_q.c[0] <= 1'b1;
            end
            if (in_sel_q[TPRM_B_T1B1]) begin
                route_q.d[4] <= timer_outs.t1b1;
                sel_q.d[4] <= 1'b1;
            end else begin
                route_q.c[1] <= timer_outs.t1b1;
                sel_q.c[1] <= 1'b1;
            end
            if (NUM_TIMERS >= 3) begin
                // timer1 out b2; shares C5 with timer0 b
                if (out_sel_q[TPRM_B_T1B2]) begin
                    route_q.d[5] <= timer_outs.t1b2;
                    sel_q.d[5] <= 1'b1;
                end else begin
                    route_q.c[5] <= timer_outs.t1b2;
                    sel_q.c[5] <= 1'b1;
                end
                if (out_sel_q[TPRM_B_T2A]) begin
                    route_q.d[6] <= timer_outs.t2a;
                    sel_q.d[6] <= 1'b1;
                end else begin
                    route_q.c[3] <= timer_outs.t2a;
                    sel_q.c[3] <= 1'b1;
                end
                if (out_sel_q[TPRM_B_T2B]) begin
                    route_q.d[7] <= timer_outs.t2b;
                    sel_q.d[7] <= 1'b1;
                end else begin
                    route_q.c[4] <= timer_outs.t2b;
                    sel_q.c[4] <= 1'b1;
                end
            end
            if (NUM_TIMERS >= 4) begin
                if (out_sel_q[TPRM_B_T3A]) begin
                    route_q.f[0] <= timer_outs.t3a;
                    sel_q.f[0] <= 1'b1;
                end else begin
                    route_q.g[3] <= timer_outs.t3a;
                    sel_q.g[3] <= 1'b1;
                end
                if (out_sel_q[TPRM_B_T3B]) begin
                    route_q.f[1] <= timer_outs.t3b;
                    sel_q.f[1] <= 1'b1;
                end else begin
                    route_q.g[0] <= timer_outs.t3b;
                    sel_q.g[0] <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Port A drive
    // output level is data latch, high by default
    assign pa_drive = pa_data_q;
    assign porta_oe = ~pa_dir_q;

    always_comb begin
        pin_out = route_q;
        // unselected Port A bits keep data latch
        pin_out.a = (route_q.a & sel_q.a) | (pa_drive & ~sel_q.a);
    end
    assign pin_timer_sel = sel_q;

    // ==========================================================
    // Input routing
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            timer_ins <= '0;
        end else begin
            timer_ins.timer2_clock_input <= in_sel_q[TPRM_B_TIMER2_CLOCK_INPUT] ? pin_in.e[2] : pin_in.c[2];
            timer_ins.timer1_clock_input <= in_sel_q[TPRM_B_TIMER1_CLOCK_INPUT] ? pin_in.e[1] : pin_in.a[4];
            timer_ins.timer0_clock_input <= in_sel_q[TPRM_B_TIMER0_CLOCK_INPUT] ? pin_in.e[0] : pin_in.a[2];
            timer_ins.irq2 <= in_sel_q[TPRM_B_IRQ2] ? pin_in.e[6] : pin_in.c[4];
            timer_ins.irq1_n <= in_sel_q[TPRM_B_IRQ1] ? pin_in.e[5] : pin_in.a[4];
            timer_ins.irq0_n <= in_sel_q[TPRM_B_IRQ0] ? pin_in.e[4] : pin_in.a[3];
        end
    end

    // ==========================================================
    // Wake-up
    tprm_wake u_wake (
        .mclk(mclk),
        .reset(reset),
        .pins(pin_in.a),
        .wake_en(wake_en_q),
        .sleep_req(sleep_req),
        .asleep(asleep),
        .wake_pulse(wake_pulse)
    );
endmodule : tprm_top

// [verilog/tprm_wake.sv]
// Port A falling edge wake detector
`timescale 1ns/100ps
module tprm_wake
    import tprm_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] pins,
    input wire logic [7:0] wake_en,
    input wire logic sleep_req,
    output logic asleep,
    output logic wake_pulse
);
    logic [7:0] prev_q;
    tprm_pwr_t state_q;
    tprm_pwr_t state_d;
    logic fall;

    // ==========================================================
    // Edge detect
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prev_q <= TPRM_PORT_RESET;
        end else begin
            prev_q <= pins;
        end
    end

    assign fall = |(prev_q & ~pins & wake_en);

    // ==========================================================
    // Power state
    always_comb begin
        state_d = state_q;
        case (state_q)
            TPRM_AWAKE: begin
                if (sleep_req) begin
                    state_d = TPRM_ASLEEP;
                end
            end
            TPRM_ASLEEP: begin
                if (fall) begin
                    state_d = TPRM_WAKING;
                end
            end
            TPRM_WAKING: begin
                state_d = TPRM_AWAKE;
            end
            default: begin
                state_d = TPRM_AWAKE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= TPRM_AWAKE;
        end else begin
            state_q <= state_d;
        end
    end

    assign asleep = (state_q == TPRM_ASLEEP);
    assign wake_pulse = (state_q == TPRM_WAKING);
endmodule : tprm_wake
